// ---- design/alu_op_decode.sv ----
// decoder for alu, compare, test, inc/dec, not/neg and unsigned multiply
// assumes opcode and modrm arrive together, sampled on i_clk
`default_nettype none
module alu_op_decode
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // fetch side
    input wire logic i_valid,
    input wire alu_decode_pkg::insn_t i_insn,
    input wire logic i_locked,
    input wire logic i_op32,
    // datapath side
    output alu_decode_pkg::decode_t o_dec
);
    import alu_decode_pkg::*;

    decode_t dec_q; // registered decode
    decode_t dec_d; // next decode
    logic [7:0] op; // opcode byte
    logic [1:0] mo; // mod field
    logic [2:0] rf; // reg field
    logic mem; // memory operand present
    logic [5:0] wr_pen; // store miss penalty

    assign op = i_insn.opcode;
    assign mo = i_insn.modrm[7:6];
    assign rf = i_insn.modrm[5:3];
    assign mem = (mo != MOD_REG);
    // locked cycles pay the short penalty
    assign wr_pen = i_locked ? PEN_LOCKED : PEN_UNLOCKED;

    // combinational decode of one instruction
    always_comb
    begin
        dec_d = '0;
        dec_d.op_class = OP_NONE;
        dec_d.full_size = op[SIZE_BIT];
        if (i_valid)
        begin
            dec_d.valid = 1'b1;
            if (op[7:6] == 2'h0 && op[2] == 1'b0)
            begin
                // two-operand alu and compare reg/mem forms
                dec_d.selector = op[5:3];
                dec_d.op_class = (op[5:3] == SEL_CMP) ? OP_CMP : OP_ALU;
                dec_d.reg_is_dest = op[DIR_BIT];
                dec_d.mem_operand = mem;
                if (!mem)
                begin
                    dec_d.hit_clocks = CLK_ONE;
                end
                else if (op[DIR_BIT] || op[5:3] == SEL_CMP)
                begin
                    dec_d.hit_clocks = CLK_TWO;
                    dec_d.miss_penalty = PEN_READ;
                end
                else
                begin
                    dec_d.hit_clocks = CLK_THREE;
                    dec_d.miss_penalty = wr_pen;
                    dec_d.writes_mem = 1'b1;
                end
                dec_d.writes_result = (op[5:3] != SEL_CMP);
            end
            else if (op[7:6] == 2'h0 && op[2:1] == 2'h2)
            begin
                // accumulator immediate forms
                dec_d.selector = op[5:3];
                dec_d.op_class = (op[5:3] == SEL_CMP) ? OP_CMP : OP_ALU;
                dec_d.reg_is_dest = 1'b1;
                dec_d.writes_result = (op[5:3] != SEL_CMP);
                dec_d.hit_clocks = CLK_ONE;
            end
            else if (op[7:2] == 6'h20)
            begin
                // immediate group with selector in reg field
                dec_d.selector = rf;
                dec_d.op_class = (rf == SEL_CMP) ? OP_CMP : OP_ALU;
                dec_d.sign_ext_imm = op[SIGN_BIT];
                dec_d.mem_operand = mem;
                dec_d.writes_result = (rf != SEL_CMP);
                dec_d.reg_is_dest = 1'b1;
                if (!mem)
                begin
                    dec_d.hit_clocks = CLK_ONE;
                end
                else if (rf == SEL_CMP)
                begin
                    dec_d.hit_clocks = CLK_TWO;
                    dec_d.miss_penalty = PEN_READ;
                end
                else
                begin
                    dec_d.hit_clocks = CLK_THREE;
                    dec_d.miss_penalty = wr_pen;
                    dec_d.writes_mem = 1'b1;
                end
            end
            else if (op[7:4] == 4'h4)
            begin
                // one-byte register inc/dec
                dec_d.op_class = OP_INCDEC;
                dec_d.selector = {2'h0, op[3]};
                dec_d.full_size = 1'b1;
                dec_d.writes_result = 1'b1;
                dec_d.hit_clocks = CLK_ONE;
            end
            else if (op[7:1] == 7'h7F &&
                     (rf == SEL_INC || rf == SEL_DEC))
            begin
                // long form inc/dec
                dec_d.op_class = OP_INCDEC;
                dec_d.selector = rf;
                dec_d.mem_operand = mem;
                dec_d.writes_result = 1'b1;
                dec_d.writes_mem = mem;
                dec_d.hit_clocks = mem ? CLK_THREE : CLK_ONE;
                dec_d.miss_penalty = mem ? wr_pen : PEN_NONE;
            end
            else if (op[7:1] == 7'h7B && rf == SEL_TEST)
            begin
                // immediate test
                dec_d.op_class = OP_TEST;
                dec_d.selector = rf;
                dec_d.mem_operand = mem;
                dec_d.hit_clocks = mem ? CLK_TWO : CLK_ONE;
                dec_d.miss_penalty = mem ? PEN_READ : PEN_NONE;
            end
            else if (op[7:1] == 7'h7B &&
                     (rf == SEL_NOT || rf == SEL_NEG))
            begin
                // complement and negate
                dec_d.op_class = OP_UNARY;
                dec_d.selector = rf;
                dec_d.mem_operand = mem;
                dec_d.writes_result = 1'b1;
                dec_d.writes_mem = mem;
                dec_d.hit_clocks = mem ? CLK_THREE : CLK_ONE;
                dec_d.miss_penalty = mem ? wr_pen : PEN_NONE;
            end
            else if (op[7:1] == 7'h7B && rf == SEL_MULU)
            begin
                // unsigned multiply, span by operand size
                dec_d.op_class = OP_MULU;
                dec_d.selector = rf;
                dec_d.mem_operand = mem;
                dec_d.writes_result = 1'b1;
                dec_d.hit_clocks = MUL_MIN;
                if (!op[SIZE_BIT])
                    dec_d.hit_clocks_max = MUL_MAX_B;
                else if (i_op32)
                    dec_d.hit_clocks_max = MUL_MAX_D;
                else
                    dec_d.hit_clocks_max = MUL_MAX_W;
                dec_d.miss_penalty = mem ? PEN_MUL : PEN_NONE;
            end
            else if (op[7:1] == 7'h42)
            begin
                // register/memory test
                dec_d.op_class = OP_TEST;
                dec_d.mem_operand = mem;
                dec_d.hit_clocks = mem ? CLK_TWO : CLK_ONE;
                dec_d.miss_penalty = mem ? PEN_READ : PEN_NONE;
            end
            else if (op[7:1] == 7'h54)
            begin
                // accumulator immediate test
                dec_d.op_class = OP_TEST;
                dec_d.hit_clocks = CLK_ONE;
            end
            else
            begin
                // not handled here
                dec_d.valid = 1'b0;
            end
            if (dec_d.op_class != OP_MULU)
                dec_d.hit_clocks_max = dec_d.hit_clocks;
        end
    end

    // register the decode
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            dec_q <= '0;
            dec_q.op_class <= OP_NONE;
        end
        else
            dec_q <= dec_d;
    end

    assign o_dec = dec_q;
endmodule : alu_op_decode
`default_nettype wire

// ---- design/alu_decode_pkg.sv ----
// constants, types and encodings for the integer alu opcode decoder
// assumes a fetch stage that presents opcode and modrm bytes together
`default_nettype none
package alu_decode_pkg;
    // operation selector codes
    localparam logic [2:0] SEL_ADD = 3'h0;
    localparam logic [2:0] SEL_OR = 3'h1;
    localparam logic [2:0] SEL_ADC = 3'h2;
    localparam logic [2:0] SEL_SBB = 3'h3;
    localparam logic [2:0] SEL_AND = 3'h4;
    localparam logic [2:0] SEL_SUB = 3'h5;
    localparam logic [2:0] SEL_XOR = 3'h6;
    localparam logic [2:0] SEL_CMP = 3'h7;
    localparam logic [2:0] SEL_INC = 3'h0;
    localparam logic [2:0] SEL_DEC = 3'h1;
    localparam logic [2:0] SEL_TEST = 3'h0;
    localparam logic [2:0] SEL_NOT = 3'h2;
    localparam logic [2:0] SEL_NEG = 3'h3;
    localparam logic [2:0] SEL_MULU = 3'h4;
    // opcode bit positions and the register mod value
    localparam int SIZE_BIT = 0;
    localparam int DIR_BIT = 1;
    localparam int SIGN_BIT = 1;
    localparam logic [1:0] MOD_REG = 2'h3;
    // clock counts
    localparam logic [5:0] CLK_ONE = 6'h01;
    localparam logic [5:0] CLK_TWO = 6'h02;
    localparam logic [5:0] CLK_THREE = 6'h03;
    localparam logic [5:0] PEN_NONE = 6'h00;
    localparam logic [5:0] PEN_READ = 6'h02;
    localparam logic [5:0] PEN_UNLOCKED = 6'h06;
    localparam logic [5:0] PEN_LOCKED = 6'h02;
    localparam logic [5:0] PEN_MUL = 6'h01;
    localparam logic [5:0] MUL_MIN = 6'h0D;
    localparam logic [5:0] MUL_MAX_B = 6'h12;
    localparam logic [5:0] MUL_MAX_W = 6'h1A;
    localparam logic [5:0] MUL_MAX_D = 6'h2A;
    // decoded operation class
    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_ALU = 7'h02,
        OP_INCDEC = 7'h04,
        OP_UNARY = 7'h08,
        OP_CMP = 7'h10,
        OP_TEST = 7'h20,
        OP_MULU = 7'h40
    } op_class_t;
    // fetched instruction bytes
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] modrm;
    } insn_t;
    // decode result
    typedef struct packed {
        logic valid;
        op_class_t op_class;
        logic [2:0] selector;
        logic full_size;
        logic sign_ext_imm;
        logic reg_is_dest;
        logic mem_operand;
        logic writes_mem;
        logic writes_result;
        logic [5:0] hit_clocks;
        logic [5:0] hit_clocks_max;
        logic [5:0] miss_penalty;
    } decode_t;
endpackage : alu_decode_pkg
`default_nettype wire

// ---- testbench/alu_op_decode_assertions.sv ----
// checker for the alu opcode decoder: class and clock-count relations
// assumes it is bound to alu_op_decode and sees only its ports
`default_nettype none
module alu_op_decode_assertions
    import alu_decode_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // watched ports
    input wire logic i_valid,
    input wire alu_decode_pkg::insn_t i_insn,
    input wire logic i_locked,
    input wire logic i_op32,
    input wire alu_decode_pkg::decode_t o_dec
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // short views of the fetched bytes
    wire logic [7:0] op = i_insn.opcode;
    wire logic [2:0] rf = i_insn.modrm[5:3];
    wire logic mem = i_insn.modrm[7:6] != MOD_REG;
    wire logic alu = i_valid && op[7:6] == 2'h0 && !op[2];
    wire logic grp = i_valid && op[7:2] == 6'h20;
    // store miss penalty picked by the locked input
    wire logic [5:0] st = i_locked ? PEN_LOCKED : PEN_UNLOCKED;
    // single-clock result with no miss penalty
    sequence s_one;
        o_dec.hit_clocks == CLK_ONE && o_dec.miss_penalty == PEN_NONE;
    endsequence
    AST_IDLE: assert property (!i_valid |=> !o_dec.valid
        && o_dec.op_class == OP_NONE) else $error("idle gave a decode");
    AST_RR_ALU: assert property (alu && !mem |=> s_one)
        else $error("reg-reg alu not one clock");
    AST_MEM_SRC: assert property (alu && op[1] && mem |=>
        o_dec.hit_clocks == CLK_TWO && o_dec.miss_penalty == PEN_READ)
        else $error("memory source timing wrong");
    AST_MEM_DST: assert property (alu && !op[1] && mem
        && op[5:3] != SEL_CMP |=> o_dec.hit_clocks == CLK_THREE
        && o_dec.miss_penalty == $past(st)) else $error("store timing");
    AST_SEL: assert property (alu |=>
        o_dec.selector == $past(op[5:3])) else $error("selector wrong");
    AST_IMM_MEM: assert property (grp && mem && rf != SEL_CMP |=>
        o_dec.hit_clocks == CLK_THREE && o_dec.miss_penalty == $past(st))
        else $error("immediate to memory timing wrong");
    AST_INC_SHORT: assert property (i_valid && op[7:4] == 4'h4 |=>
        s_one ##0 o_dec.op_class == OP_INCDEC) else $error("short inc");
    AST_CMP_FLAGS: assert property (i_valid && op[7:2] == 6'h0E
        && !mem |=> s_one ##0 !o_dec.writes_result && !o_dec.writes_mem)
        else $error("register compare writes a result");
    AST_MUL: assert property (i_valid && op[7:1] == 7'h7B
        && rf == SEL_MULU |=> o_dec.hit_clocks == MUL_MIN
        && o_dec.hit_clocks_max == (!$past(op[0]) ? MUL_MAX_B
        : $past(i_op32) ? MUL_MAX_D : MUL_MAX_W)
        && o_dec.miss_penalty == ($past(mem) ? PEN_MUL : PEN_NONE))
        else $error("multiply counts wrong");
    AST_DIR: assert property (alu |=>
        o_dec.reg_is_dest == $past(op[1])) else $error("direction wrong");
    AST_SIZE: assert property (alu |=>
        o_dec.full_size == $past(op[0])) else $error("size bit wrong");
    AST_SIGN: assert property (grp |=>
        o_dec.sign_ext_imm == $past(op[1])) else $error("sign bit wrong");
    AST_NO_PUSH: assert property (i_valid && op[7:4] == 4'h5 |=>
        !o_dec.valid) else $error("push or pop taken as inc/dec");
endmodule : alu_op_decode_assertions
bind alu_op_decode alu_op_decode_assertions u_chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_valid(i_valid), .i_insn(i_insn),
    .i_locked(i_locked), .i_op32(i_op32), .o_dec(o_dec));
`default_nettype wire

// ---- testbench/fetch_stream_model.sv ----
// fetch stream model: one instruction per cycle toward the decoder
// assumes the bench calls issue once per cycle
`default_nettype none
module fetch_stream_model
    import alu_decode_pkg::*;
(
    // clock
    input wire logic i_clk,
    // fetch outputs
    output var logic o_valid,
    output var alu_decode_pkg::insn_t o_insn,
    output var logic o_locked,
    output var logic o_op32
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle until the first instruction
    initial
    begin
        o_valid = 1'b0;
        o_insn = '0;
        o_locked = 1'b0;
        o_op32 = 1'b0;
    end
    // drive at the falling edge; idle bytes never repeat the last ones
    task automatic issue(input logic v, input insn_t n, input logic l,
        input logic w);
        @(negedge i_clk);
        o_valid = v;
        o_insn = v ? n : ~o_insn;
        o_locked = l;
        o_op32 = w;
    endtask : issue
endmodule : fetch_stream_model
`default_nettype wire

// ---- testbench/integer_alu_op_decode_timing_tb_top.sv ----
// self-checking bench for the alu opcode decoder
// assumes the fetch model drives inputs at the falling edge
`default_nettype none
`define CMP(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module integer_alu_op_decode_timing_tb_top
    import alu_decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    int bad_count = 0;
    int checked = 0;
    wire logic v, lk, w32;
    wire insn_t insn;
    wire decode_t dec;
    // free-running core clock
    always #2.5 i_clk = ~i_clk;
    fetch_stream_model fm (.i_clk(i_clk), .o_valid(v), .o_insn(insn),
        .o_locked(lk), .o_op32(w32));
    alu_op_decode dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(v),
        .i_insn(insn), .i_locked(lk), .i_op32(w32), .o_dec(dec));
    // issue one instruction and judge the decode 1 ns after the next rising edge
    task automatic chk(input logic a, input logic [15:0] n, input logic l,
        input logic w, input op_class_t c, input logic [5:0] h,
        input logic [5:0] m, input logic [5:0] p);
        fm.issue(a, n, l, w);
        @(posedge i_clk);
        #1;
        `CMP("decode", {c != OP_NONE, c, h, m, p}, {dec.valid, dec.op_class,
            dec.hit_clocks, dec.hit_clocks_max, dec.miss_penalty})
    endtask : chk
    // every selector in register, memory and immediate forms
    task automatic t_alu;
        op_class_t c;
        logic [7:0] o;
        logic [5:0] h, p;
        for (int s = 0; s < 8; s++)
        begin
            o = {2'h0, s[2:0], 3'h0};
            c = (s == 7) ? OP_CMP : OP_ALU;
            h = (s == 7) ? 6'h02 : 6'h03;
            p = (s == 7) ? 6'h02 : (s[0] ? 6'h02 : 6'h06);
            chk(1, {o, 8'hC1}, 0, 0, c, 6'h01, 6'h01, 6'h00);
            chk(1, {o | 8'h03, 8'hC1}, 0, 1, c, 6'h01, 6'h01, 6'h00);
            chk(1, {o | 8'h02, 8'h00}, s[0], 0, c, 6'h02, 6'h02, 6'h02);
            chk(1, {o | 8'h01, 8'h00}, s[0], 0, c, h, h, p);
            chk(1, {o | 8'h05, 8'h00}, 0, 0, c, 6'h01, 6'h01, 6'h00);
            chk(1, {8'h83, 2'h3, s[2:0], 3'h2}, 0, 0, c, 6'h01, 6'h01,
                6'h00);
            chk(1, {8'h80, 2'h1, s[2:0], 3'h2}, s[0], 0, c, h, h, p);
        end
        $display("t_alu done");
    endtask : t_alu
    // inc/dec, complement/negate and test forms
    task automatic t_unary;
        chk(1, 16'hFEC0, 0, 0, OP_INCDEC, 6'h01, 6'h01, 6'h00);
        chk(1, 16'h4F00, 0, 0, OP_INCDEC, 6'h01, 6'h01, 6'h00);
        chk(1, 16'hFF08, 1, 0, OP_INCDEC, 6'h03, 6'h03, 6'h02);
        chk(1, 16'hF7D8, 0, 0, OP_UNARY, 6'h01, 6'h01, 6'h00);
        chk(1, 16'hF610, 0, 0, OP_UNARY, 6'h03, 6'h03, 6'h06);
        chk(1, 16'h84C0, 0, 0, OP_TEST, 6'h01, 6'h01, 6'h00);
        chk(1, 16'h8510, 0, 0, OP_TEST, 6'h02, 6'h02, 6'h02);
        chk(1, 16'hF6C0, 0, 0, OP_TEST, 6'h01, 6'h01, 6'h00);
        chk(1, 16'hF700, 0, 0, OP_TEST, 6'h02, 6'h02, 6'h02);
        chk(1, 16'hA900, 0, 0, OP_TEST, 6'h01, 6'h01, 6'h00);
        $display("t_unary done");
    endtask : t_unary
    // multiply bounds for each size in register form, and word size from memory
    task automatic t_mul;
        chk(1, 16'hF6E0, 0, 1, OP_MULU, 6'h0D, 6'h12, 6'h00);
        chk(1, 16'hF7E0, 0, 0, OP_MULU, 6'h0D, 6'h1A, 6'h00);
        chk(1, 16'hF7E0, 0, 1, OP_MULU, 6'h0D, 6'h2A, 6'h00);
        chk(1, 16'hF720, 0, 0, OP_MULU, 6'h0D, 6'h1A, 6'h01);
        $display("t_mul done");
    endtask : t_mul
    // idle cycle, unsupported opcode and a reset in mid-run
    task automatic t_refuse;
        chk(0, 16'h01C0, 0, 0, OP_NONE, 6'h00, 6'h00, 6'h00);
        chk(1, 16'h8BC0, 0, 0, OP_NONE, 6'h00, 6'h00, 6'h00);
        chk(1, 16'h5000, 0, 0, OP_NONE, 6'h00, 6'h00, 6'h00);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        chk(1, 16'h01C0, 0, 0, OP_NONE, 6'h00, 6'h00, 6'h00);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        @(posedge i_clk);
        chk(1, 16'h29C0, 0, 0, OP_ALU, 6'h01, 6'h01, 6'h00);
        $display("t_refuse done");
    endtask : t_refuse
    // print the counts and the verdict, then stop
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // main sequence
    initial
    begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(posedge i_clk);
        t_alu();
        t_unary();
        t_mul();
        t_refuse();
        conclude();
    end
    // hang guard
    initial
    begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        conclude();
    end
endmodule : integer_alu_op_decode_timing_tb_top
`default_nettype wire
